// *** rtl/crs_defines.vh ***
/*
 * Constants of the CPU reset sequencer: register offsets, field positions,
 * reset values and timing counts.
 * Assumes it is included by bare name from the sequencer design files.
 */
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// ****************************************************************
// Timing
// ****************************************************************
`define CRS_RST_MIN_STATES  8'hA0
`define CRS_RST_MIN_CYC     (`CRS_RST_MIN_STATES)
`define CRS_CNT_W           8

// ****************************************************************
// Reset vector and internal I/O window
// ****************************************************************
`define CRS_VEC_BASE        24'hFF_FF00
`define CRS_VEC_LAST_IDX    2'h2
`define CRS_IO_BASE         24'h00_0000
`define CRS_IO_LAST         24'h00_007F

// ****************************************************************
// Reset values
// ****************************************************************
`define CRS_SP_RST          32'h0000_0100
`define CRS_IMASK_RST       3'h7
`define CRS_MAX_RST         1'h1
`define CRS_BANK_RST        3'h0
`define CRS_CTRL_RST        8'h00

// ****************************************************************
// Status word fields
// ****************************************************************
`define CRS_SR_IMASK_LO     12
`define CRS_SR_MAX_BIT      11
`define CRS_SR_BANK_LO      8

// ****************************************************************
// Register offsets inside the I/O window
// ****************************************************************
`define CRS_OFF_CTRL        7'h00
`define CRS_OFF_PC          7'h04
`define CRS_OFF_SR          7'h08
`define CRS_OFF_SP          7'h0C
`define CRS_OFF_GPR         7'h10
`define CRS_OFF_RAMADDR     7'h14
`define CRS_OFF_RAMDATA     7'h18
`define CRS_OFF_STAT        7'h1C

`define CRS_RAM_DEPTH       16
`define CRS_RAM_AW          4

`endif

// *** rtl/crs_pin_sync.v ***
/*
 * Three-stage synchroniser for an asynchronous pin.
 * Assumes the pin idles high; the output changes only when stages two and three agree.
 */
`default_nettype none
`include "crs_defines.vh"

module crs_pin_sync (
   // Clock and reset
   input  wire mclk,
   input  wire rst,
   // Pin and filtered level
   input  wire pinIn,
   output reg  pinOut
);

   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         s1_reg <= 1'b1;
         s2_reg <= 1'b1;
         s3_reg <= 1'b1;
         pinOut <= 1'b1;
      end else begin
         s1_reg <= pinIn;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         // First stage feeds only the second
         if (s2_reg == s3_reg) begin
            pinOut <= s3_reg;
         end
      end
   end

endmodule // crs_pin_sync
`default_nettype wire

// *** rtl/crs_reset_seq.v ***
/*
 * CPU reset sequencer: filters the reset pin, holds the core in reset,
 * fetches the three-byte reset vector, loads PC, stack pointer and status
 * word, then starts the core. Avalon-MM slave for the internal I/O window.
 * Assumes one clock mclk, a vector memory answering vecReq with a vecAck pulse,
 * and an Avalon master that holds its request until waitrequest is low.
 */
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`default_nettype none
`include "crs_defines.vh"

module crs_reset_seq (
   // Clock and reset
   input  wire        mclk,
   input  wire        rst,
   // Reset pin
   input  wire        resetPinN,
   // Avalon-MM slave
   input  wire [23:0] avsAddress,
   input  wire        avsRead,
   input  wire        avsWrite,
   input  wire [31:0] avsWriteData,
   output reg  [31:0] avsReadData,
   output reg         avsWaitRequest,
   // Reset vector memory
   output reg         vecReq,
   output reg  [23:0] vecAddr,
   input  wire        vecAck,
   input  wire [7:0]  vecData,
   // Core control
   output reg         coreRstOut,
   output reg         coreRunStart,
   output reg  [23:0] coreFetchAddr,
   output reg  [15:0] statusWord,
   output reg  [31:0] stackPtr,
   // Pins
   output reg         clkOut,
   output reg         aleOut,
   output reg         aleOe,
   output reg  [7:0]  portFuncSel
);

   // ****************************************************************
   // States
   // ****************************************************************
   localparam [1:0] ST_HOLD  = 2'h0;
   localparam [1:0] ST_FETCH = 2'h1;
   localparam [1:0] ST_START = 2'h2;
   localparam [1:0] ST_RUN   = 2'h3;

   reg  [1:0]           state_reg;
   reg  [1:0]           vecIdx_reg;
   reg  [23:0]          pc_reg;
   reg  [`CRS_CNT_W-1:0] lowCnt_reg;
   reg  [1:0]           div_reg;
   reg  [31:0]          gpr_reg;
   reg  [`CRS_RAM_AW-1:0] ramAddr_reg;
   reg  [31:0]          ram [0:`CRS_RAM_DEPTH-1];
   reg  [31:0]          rdMux;

   wire                 pinLevel;
   wire                 inWindow;
   wire [6:0]           regOff;
   wire                 wrAck;
   wire                 lowReached;
   wire                 inReset;

   localparam [`CRS_CNT_W-1:0] RST_MIN = `CRS_RST_MIN_CYC;

   // ****************************************************************
   // Reset pin filter
   // ****************************************************************
   crs_pin_sync uPinSync (
      .mclk   (mclk),
      .rst    (rst),
      .pinIn  (resetPinN),
      .pinOut (pinLevel)
   );

   // Consecutive low samples, saturating at the minimum
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         lowCnt_reg <= {`CRS_CNT_W{1'b0}};
      end else if (pinLevel) begin
         lowCnt_reg <= {`CRS_CNT_W{1'b0}};
      end else if (lowCnt_reg != RST_MIN) begin
         lowCnt_reg <= lowCnt_reg + 1'b1;
      end
   end

   // A shorter pulse is ignored as a glitch
   assign lowReached = (lowCnt_reg == RST_MIN);
   assign inReset    = (state_reg == ST_HOLD);

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // Short direct addresses land here: only the low seven bits select
   assign inWindow = (avsAddress <= `CRS_IO_LAST);
   assign regOff   = avsAddress[6:0];
   assign wrAck    = avsWrite & ~avsWaitRequest & inWindow;

   always @* begin
      rdMux = 32'h0000_0000;
      if (inWindow) begin
         case (regOff)
            `CRS_OFF_CTRL:    rdMux = {24'h00_0000, portFuncSel};
            `CRS_OFF_PC:      rdMux = {8'h00, pc_reg};
            `CRS_OFF_SR:      rdMux = {16'h0000, statusWord};
            `CRS_OFF_SP:      rdMux = stackPtr;
            `CRS_OFF_GPR:     rdMux = gpr_reg;
            `CRS_OFF_RAMADDR: rdMux = {28'h000_0000, ramAddr_reg};
            `CRS_OFF_RAMDATA: rdMux = ram[ramAddr_reg];
            `CRS_OFF_STAT:    rdMux = {20'h0_0000, lowCnt_reg, coreRstOut, pinLevel, state_reg};
            default:          rdMux = 32'h0000_0000;
         endcase
      end
   end

   // One wait cycle per request, then a single acknowledge cycle
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         avsWaitRequest <= 1'b1;
         avsReadData    <= 32'h0000_0000;
      end else if ((avsRead | avsWrite) & avsWaitRequest) begin
         avsWaitRequest <= 1'b0;
         avsReadData    <= rdMux;
      end else begin
         avsWaitRequest <= 1'b1;
      end
   end

   // ****************************************************************
   // Registers kept across a pin reset
   // ****************************************************************
   // Only power-on clears the general register; pin reset leaves it alone
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         gpr_reg     <= 32'h0000_0000;
         ramAddr_reg <= {`CRS_RAM_AW{1'b0}};
      end else if (wrAck) begin
         if (regOff == `CRS_OFF_GPR) begin
            gpr_reg <= avsWriteData;
         end
         if (regOff == `CRS_OFF_RAMADDR) begin
            ramAddr_reg <= avsWriteData[`CRS_RAM_AW-1:0];
         end
      end
   end

   // RAM has no reset so its contents survive any reset
   always @(posedge mclk) begin
      if (wrAck && (regOff == `CRS_OFF_RAMDATA)) begin
         ram[ramAddr_reg] <= avsWriteData;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_reg     <= ST_HOLD;
         vecIdx_reg    <= 2'h0;
         vecReq        <= 1'b0;
         vecAddr       <= `CRS_VEC_BASE;
         pc_reg        <= 24'h00_0000;
         coreRstOut    <= 1'b1;
         coreRunStart  <= 1'b0;
         coreFetchAddr <= 24'h00_0000;
      end else begin
         coreRunStart <= 1'b0;
         if (lowReached && (state_reg != ST_HOLD)) begin
            state_reg  <= ST_HOLD;
            vecReq     <= 1'b0;
            coreRstOut <= 1'b1;
         end else begin
            case (state_reg)
               ST_HOLD: begin
                  coreRstOut <= 1'b1;
                  vecIdx_reg <= 2'h0;
                  vecAddr    <= `CRS_VEC_BASE;
                  if (pinLevel) begin
                     state_reg <= ST_FETCH;
                     vecReq    <= 1'b1;
                  end
               end
               ST_FETCH: begin
                  if (vecReq && vecAck) begin
                     // Byte n of the vector fills PC bits 8n+7..8n
                     pc_reg[vecIdx_reg*8 +: 8] <= vecData;
                     vecReq <= 1'b0;
                     if (vecIdx_reg == `CRS_VEC_LAST_IDX) begin
                        state_reg <= ST_START;
                     end else begin
                        vecIdx_reg <= vecIdx_reg + 2'h1;
                        vecAddr    <= vecAddr + 24'h00_0001;
                     end
                  end else if (!vecReq) begin
                     // Gap cycle keeps each acknowledge tied to one address
                     vecReq <= 1'b1;
                  end
               end
               ST_START: begin
                  coreRstOut    <= 1'b0;
                  coreRunStart  <= 1'b1;
                  coreFetchAddr <= pc_reg;
                  state_reg     <= ST_RUN;
               end
               ST_RUN: begin
                  coreRstOut <= 1'b0;
               end
               default: begin
                  state_reg <= ST_HOLD;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Status word and stack pointer
   // ****************************************************************
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         stackPtr   <= `CRS_SP_RST;
         statusWord <= 16'h0000;
         statusWord[`CRS_SR_IMASK_LO +: 3] <= `CRS_IMASK_RST;
         statusWord[`CRS_SR_MAX_BIT]       <= `CRS_MAX_RST;
         statusWord[`CRS_SR_BANK_LO +: 3]  <= `CRS_BANK_RST;
      end else if (state_reg != ST_RUN) begin
         // Hardware values win over software until the core runs
         stackPtr <= `CRS_SP_RST;
         statusWord[`CRS_SR_IMASK_LO +: 3] <= `CRS_IMASK_RST;
         statusWord[`CRS_SR_MAX_BIT]       <= `CRS_MAX_RST;
         statusWord[`CRS_SR_BANK_LO +: 3]  <= `CRS_BANK_RST;
      end else if (wrAck) begin
         if (regOff == `CRS_OFF_SP) begin
            stackPtr <= avsWriteData;
         end
         if (regOff == `CRS_OFF_SR) begin
            // Minimum mode does not exist, so the mode flag stays set
            statusWord[`CRS_SR_IMASK_LO +: 3] <= avsWriteData[`CRS_SR_IMASK_LO +: 3];
            statusWord[`CRS_SR_BANK_LO +: 3]  <= avsWriteData[`CRS_SR_BANK_LO +: 3];
            statusWord[`CRS_SR_MAX_BIT]       <= `CRS_MAX_RST;
         end
      end
   end

   // ****************************************************************
   // Peripheral control and pins
   // ****************************************************************
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         portFuncSel <= `CRS_CTRL_RST;
      end else if (inReset) begin
         portFuncSel <= `CRS_CTRL_RST;
      end else if (wrAck && (regOff == `CRS_OFF_CTRL)) begin
         portFuncSel <= avsWriteData[7:0];
      end
   end

   // Clock output is mclk/4; ALE marks the last quarter of each cycle, just before the clock rises
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_reg <= 2'h0;
         clkOut  <= 1'b1;
         aleOut  <= 1'b0;
         aleOe   <= 1'b0;
      end else if (inReset) begin
         div_reg <= 2'h0;
         clkOut  <= 1'b1;
         aleOut  <= 1'b0;
         aleOe   <= 1'b0;
      end else begin
         div_reg <= div_reg + 2'h1;
         clkOut  <= ~div_reg[1];
         aleOut  <= (div_reg == 2'h3);
         aleOe   <= 1'b1;
      end
   end

endmodule // crs_reset_seq
`default_nettype wire

// *** testbench/cpu_reset_sequencer_test.sv ***
/* Self-checking bench for the reset sequencer.
   Assumes the 160-sample filter and the vector model beside it. */
`default_nettype none
module cpu_reset_sequencer_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic wr; logic [23:0] a; logic [31:0] d;} crs_row_t;
   // Arbitrary start address
   localparam logic [23:0] VEC = 24'h01_2345;
   logic        mclk, rst, resetPinN, avsRead, avsWrite, vecReq, vecAck, slowAck;
   logic        coreRstOut, coreRunStart, avsWaitRequest, clkOut, aleOe, aleOut;
   logic [23:0] avsAddress, vecAddr, coreFetchAddr;
   logic [31:0] avsWriteData, avsReadData, stackPtr, q;
   logic [15:0] statusWord;
   logic [7:0]  vecData, portFuncSel;
   int          nErrors, comparisons;
   crs_row_t    rows[20] = '{
      '{0, 24'h00_0004, {8'h00, VEC}}, '{0, 24'h00_0008, 32'h0000_7800},
      '{0, 24'h00_000C, 32'h0000_0100}, '{0, 24'h00_0020, 32'h0000_0000},
      '{0, 24'h00_0080, 32'h0000_0000}, '{1, 24'h00_0010, 32'hCAFE_F00D},
      '{1, 24'h00_0014, 32'h0000_0003}, '{1, 24'h00_0018, 32'h1234_5678},
      '{1, 24'h00_0000, 32'h0000_00A5}, '{1, 24'h00_0008, 32'h0000_0300},
      '{1, 24'h00_000C, 32'h0000_2000}, '{0, 24'h00_0008, 32'h0000_0B00},
      '{0, 24'h00_0000, 32'h0000_00A5}, '{0, 24'h00_000C, 32'h0000_2000},
      '{0, 24'h00_0010, 32'hCAFE_F00D}, '{1, 24'h00_0014, 32'h0000_0003},
      '{0, 24'h00_0018, 32'h1234_5678}, '{0, 24'h00_0000, 32'h0000_0000},
      '{0, 24'h00_0008, 32'h0000_7800}, '{0, 24'h00_000C, 32'h0000_0100}};
   crs_reset_seq crs_reset_seq_i (.mclk(mclk), .rst(rst), .resetPinN(resetPinN),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .vecReq(vecReq),
      .vecAddr(vecAddr), .vecAck(vecAck), .vecData(vecData), .coreRstOut(coreRstOut),
      .coreRunStart(coreRunStart), .coreFetchAddr(coreFetchAddr), .statusWord(statusWord),
      .stackPtr(stackPtr), .clkOut(clkOut), .aleOut(aleOut), .aleOe(aleOe), .portFuncSel(portFuncSel));
   crs_vec_model #(.VECTOR(VEC)) crs_vec_model_i (.mclk(mclk), .rst(rst), .slowAck(slowAck),
      .vecReq(vecReq), .vecAddr(vecAddr), .vecAck(vecAck), .vecData(vecData));
   always #50 mclk = ~mclk;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nErrors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [23:0] a, input logic [31:0] d);
      @(posedge mclk);
      avsAddress <= a;
      avsWriteData <= d;
      avsRead <= !wr;
      avsWrite <= wr;
      @(posedge mclk);
      while (avsWaitRequest !== 1'b0) @(posedge mclk);
      q = avsReadData;
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
   endtask
   task automatic run_rows(input int first, input int last);
      for (int i = first; i <= last; i++) begin
         bus(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) check("read data", q, rows[i].d);
      end
   endtask
   task automatic wait_start();
      for (int i = 0; i < 300 && coreRunStart !== 1'b1; i++) @(posedge mclk);
      check("start pulse", {31'h0, coreRunStart}, 32'h0000_0001);
      check("start address", {8'h00, coreFetchAddr}, {8'h00, VEC});
      check("core reset", {31'h0, coreRstOut}, 32'h0000_0000);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge mclk);
      nErrors++;
      $display("timeout");
      test_done();
   end
   initial begin
      {mclk, rst, resetPinN, avsRead, avsWrite, slowAck} = 6'b011000;
      avsAddress = 24'h00_0000;
      avsWriteData = 32'h0000_0000;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      wait_start();
      run_rows(0, 13);
      $display("table done");
      resetPinN <= 1'b0;
      repeat (100) @(posedge mclk);
      check("short pulse", {31'h0, coreRstOut}, 32'h0000_0000);
      resetPinN <= 1'b1;
      slowAck <= 1'b1;
      $display("short pulse done");
      repeat (2) @(posedge mclk);
      resetPinN <= 1'b0;
      repeat (200) @(posedge mclk);
      check("pins in reset", {20'h0, clkOut, aleOe, aleOut, portFuncSel, coreRstOut}, 32'h0000_0801);
      resetPinN <= 1'b1;
      @(posedge mclk);
      wait_start();
      run_rows(14, 19);
      $display("pin reset done");
      test_done();
   end
endmodule // cpu_reset_sequencer_test
`default_nettype wire

// *** testbench/crs_reset_seq_asserts.sv ***
/* Concurrent checks on the reset sequencer ports.
   Assumes binding to crs_reset_seq; pin reset runs well past the filter. */
`default_nettype none
module crs_reset_seq_asserts (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        resetPinN,
   // Bus
   input wire logic [23:0] avsAddress,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsReadData,
   input wire logic        avsWaitRequest,
   // Vector port
   input wire logic        vecReq,
   input wire logic [23:0] vecAddr,
   input wire logic        vecAck,
   input wire logic [7:0]  vecData,
   // Core and pins
   input wire logic        coreRstOut,
   input wire logic        coreRunStart,
   input wire logic [23:0] coreFetchAddr,
   input wire logic [15:0] statusWord,
   input wire logic [31:0] stackPtr,
   input wire logic        clkOut,
   input wire logic        aleOe,
   input wire logic [7:0]  portFuncSel
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0]  lowRun;
   logic [23:0] pcSeen;
   logic        inHold;
   // Past 180 low samples the filter must have fired
   assign inHold = lowRun > 9'h0B4;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lowRun <= 9'h000;
         pcSeen <= 24'h00_0000;
      end else begin
         lowRun <= resetPinN ? 9'h000 : (lowRun == 9'h1FF ? lowRun : lowRun + 9'h001);
         if (vecReq && vecAck) pcSeen[{vecAddr[1:0], 3'b000} +: 8] <= vecData;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_clk_pulled: assert property (inHold |-> clkOut)
      else $error("clock pin low in reset");
   a_ale_float: assert property (inHold |-> !aleOe)
      else $error("ALE driven in reset");
   a_port_mode: assert property (inHold |-> portFuncSel == 8'h00)
      else $error("pin not in port mode");
   a_sp_load: assert property (inHold |-> stackPtr == 32'h0000_0100)
      else $error("stack pointer not reset");
   a_mask_bank: assert property (inHold |-> statusWord[14:8] == 7'h78)
      else $error("status fields not reset");
   a_max_kept: assert property (statusWord[11])
      else $error("max flag cleared");
   a_start_vec: assert property (coreRunStart |-> coreFetchAddr == pcSeen && !coreRstOut)
      else $error("start address differs from vector");
   a_vec_range: assert property (vecReq |-> vecAddr >= 24'hFF_FF00 && vecAddr <= 24'hFF_FF02)
      else $error("vector address out of range");
   a_vec_step: assert property (vecReq && vecAck && vecAddr[1:0] != 2'h2 |=>
      !vecReq ##1 vecAddr == $past(vecAddr, 2) + 24'h00_0001)
      else $error("vector bytes out of order");
   a_pulse_ignored: assert property (lowRun != 9'h000 && lowRun < 9'h09C && $past(!coreRstOut)
      |-> !coreRstOut)
      else $error("short pin pulse took effect");
   a_req_answer: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
      else $error("bus request not answered");
   a_out_window: assert property (avsRead && !avsWaitRequest && avsAddress > 24'h00_007F
      |-> avsReadData == 32'h0000_0000)
      else $error("read outside window not zero");
   c_start: cover property (coreRunStart);
   c_hold: cover property (inHold);
   c_read: cover property (avsRead && !avsWaitRequest);
endmodule // crs_reset_seq_asserts
bind crs_reset_seq crs_reset_seq_asserts crs_reset_seq_asserts_i (.mclk, .rst, .resetPinN,
   .avsAddress, .avsRead, .avsWrite, .avsReadData, .avsWaitRequest, .vecReq, .vecAddr, .vecAck,
   .vecData, .coreRstOut, .coreRunStart, .coreFetchAddr, .statusWord, .stackPtr, .clkOut,
   .aleOe, .portFuncSel);
`default_nettype wire

// *** testbench/crs_vec_model.sv ***
/* Vector memory model: answers each byte request after a chosen delay.
   Assumes one clock shared with the sequencer. */
`default_nettype none
module crs_vec_model #(
   parameter logic [23:0] VECTOR = 24'h01_2345
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        slowAck,
   input  wire logic        vecReq,
   input  wire logic [23:0] vecAddr,
   output var  logic        vecAck,
   output var  logic [7:0]  vecData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] waitCnt;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vecAck  <= 1'b0;
         vecData <= 8'h00;
         waitCnt <= 3'h0;
      end else if (vecReq && !vecAck && waitCnt >= (slowAck ? 3'h4 : 3'h0)) begin
         vecAck  <= 1'b1;
         vecData <= VECTOR[{vecAddr[1:0], 3'b000} +: 8];
         waitCnt <= 3'h0;
      end else begin
         vecAck  <= 1'b0;
         // Stale byte must not look valid
         vecData <= ~vecData;
         waitCnt <= (vecReq && !vecAck) ? waitCnt + 3'h1 : 3'h0;
      end
   end
endmodule // crs_vec_model
`default_nettype wire
